// File: rtl/fcg_pkg.sv
// constants, enumerations and register map of the four channel gated counter
package fcg_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_EV = 6;
   localparam int ADDR_W = 12;
   // per channel config block, stride 0x20
   localparam logic [11:0] OFS_CH_STRIDE = 12'h020;
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_LOAD = 5'h04;
   localparam logic [4:0] OFS_END = 5'h08;
   localparam logic [4:0] OFS_CMP = 5'h0c;
   localparam logic [4:0] OFS_START = 5'h10;
   localparam logic [11:0] OFS_IRQ_SEL = 12'h100;
   localparam logic [11:0] OFS_IRQ_STS = 12'h104;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h108;
   localparam logic [11:0] OFS_COUNT0 = 12'h330;
   localparam logic [11:0] OFS_COUNT1 = 12'h334;
   localparam logic [11:0] OFS_COUNT2 = 12'h338;
   localparam logic [11:0] OFS_COUNT3 = 12'h33c;
   // config word fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_MDIR_LSB = 2;
   localparam int CFG_STOP = 4;
   localparam int CFG_EVAL_LSB = 5;
   localparam int CFG_INV = 7;
   localparam int CFG_HWG = 8;
   localparam int CFG_SWG = 9;
   localparam int CFG_EVT_LSB = 16;
   // event positions inside one channel's slice of status and mask
   localparam int EV_GOPEN = 0;
   localparam int EV_GCLOSE = 1;
   localparam int EV_CMP = 2;
   localparam int EV_PULSE = 3;
   localparam int EV_OVF = 4;
   localparam int EV_UNF = 5;
   localparam int STS_LOST = 24;
   localparam int STS_W = 25;
   // reset values and limits
   localparam logic [31:0] CNT_MAX = 32'h7fffffff;
   localparam logic [31:0] CNT_MIN = 32'h80000000;
   localparam logic [31:0] START_RST = 32'h7fffffff;
   localparam logic [31:0] END_RST = 32'h7fffffff;
   localparam logic [31:0] END_MIN = 32'h00000002;
   localparam logic [31:0] LOAD_RST = 32'h00000000;
   localparam logic [31:0] CMP_RST = 32'h00000000;
   localparam logic [31:0] CNT_RST = 32'h00000000;

   typedef enum logic [1:0] {
      FCG_UNCONF = 2'h0,
      FCG_ENDLESS = 2'h1,
      FCG_ONCE = 2'h3,
      FCG_PERIODIC = 2'h2
   } fcg_mode_e;

   typedef enum logic [1:0] {
      FCG_DIR_NONE = 2'h0,
      FCG_DIR_UP = 2'h1,
      FCG_DIR_DOWN = 2'h2
   } fcg_mdir_e;

   typedef enum logic [1:0] {
      FCG_EV_PULSEDIR = 2'h0,
      FCG_EV_SINGLE = 2'h1,
      FCG_EV_DOUBLE = 2'h2,
      FCG_EV_QUAD = 2'h3
   } fcg_eval_e;

   typedef enum logic [1:0] {
      FCG_IRQ_NONE = 2'h0,
      FCG_IRQ_PROC = 2'h1,
      FCG_IRQ_DIAG = 2'h2
   } fcg_irqsel_e;
endpackage : fcg_pkg

// File: rtl/fcg_counter.sv
// four channel gated pulse and encoder counter with apb registers
//
// Contract
// R1: four channels, each count read as signed 32-bit word at own address
// R2: interrupt selection none raises no interrupt at all; flags already pending in sts still drive irq while unmasked
// R3: process selection raises enabled gate, compare, pulse, overflow, underflow events
// R4: diagnostics selection raises lost flag only when an event was lost
// R5: modes unconfigured, endless, once, periodical; unconfigured deactivates channel
// R6: no main direction leaves counting range unrestricted
// R7: main up counts to end minus one, next up pulse returns to load
// R8: main down counts to one, next down pulse jumps to start
// R9: main direction restriction ignored in endless mode
// R10: cancel policy starts on opening, every reopening reloads load value
// R11: stop policy pauses on closing, resumes from last value
// R12: after reset no main direction and cancel gate policy
// R13: start defaults to 2^31-1; end settable 2 up to 2^31-1
// R14: channel 3 hardware gate enable combines hardware and software gate
// R15: input evaluated as pulse/direction or encoder single, double, quadruple
// R16: direction inversion flips direction before it is used
// R17: overflow and underflow flagged in the same cycle as the wrap
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module fcg_counter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [fcg_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [fcg_pkg::NUM_CH-1:0] cnt_a,
   input wire logic [fcg_pkg::NUM_CH-1:0] cnt_b,
   input wire logic hw_gate,
   output logic irq
);
   import fcg_pkg::*;

   typedef struct packed {
      fcg_mode_e mode;
      fcg_mdir_e mdir;
      logic stop;
      fcg_eval_e eval;
      logic inv;
      logic hwg;
      logic swg;
      logic [NUM_EV-1:0] evt_en;
      logic [31:0] load;
      logic [31:0] endv;
      logic [31:0] cmp;
      logic [31:0] start;
      logic [31:0] cnt;
      logic done;
      logic gate_q;
   } fcg_ch_s;

   typedef struct packed {
      fcg_ch_s [NUM_CH-1:0] ch;
      logic [2*NUM_CH:0] s1;
      logic [2*NUM_CH:0] s2;
      logic [2*NUM_CH:0] s3;
      logic [2*NUM_CH:0] filt;
      fcg_irqsel_e irq_sel;
      logic [STS_W-1:0] sts;
      logic [STS_W-1:0] mask;
      logic [31:0] prdata;
      logic err;
   } fcg_state_s;

   localparam fcg_ch_s CH_RST = '{
      mode: FCG_UNCONF,
      mdir: FCG_DIR_NONE,
      stop: 1'b0,
      eval: FCG_EV_PULSEDIR,
      inv: 1'b0,
      hwg: 1'b0,
      swg: 1'b0,
      evt_en: '0,
      load: LOAD_RST,
      endv: END_RST,
      cmp: CMP_RST,
      start: START_RST,
      cnt: CNT_RST,
      done: 1'b0,
      gate_q: 1'b0
   };

   fcg_state_s st_r;
   fcg_state_s st_nxt;

   logic setup;
   logic access_wr;
   assign setup = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   // every access completes in one access cycle; read data is caught in setup
   assign pready = psel & penable;
   assign prdata = st_r.prdata;
   assign pslverr = st_r.err & psel & penable;
   assign irq = |(st_r.sts & st_r.mask);

   function automatic logic [31:0] fcg_cfg_word(input fcg_ch_s c);
      logic [31:0] w;
      w = '0;
      w[CFG_MODE_LSB +: 2] = c.mode;
      w[CFG_MDIR_LSB +: 2] = c.mdir;
      w[CFG_STOP] = c.stop;
      w[CFG_EVAL_LSB +: 2] = c.eval;
      w[CFG_INV] = c.inv;
      w[CFG_HWG] = c.hwg;
      w[CFG_SWG] = c.swg;
      w[CFG_EVT_LSB +: NUM_EV] = c.evt_en;
      return w;
   endfunction : fcg_cfg_word

   always_comb begin
      logic a;
      logic b;
      logic ea;
      logic eb;
      logic hw;
      logic hw_rise;
      logic hw_fall;
      logic pulse;
      logic up;
      logic gate;
      logic run;
      logic ovf;
      logic unf;
      logic [31:0] nv;
      logic [NUM_CH*NUM_EV-1:0] ev;
      logic [STS_W-1:0] set;
      logic [STS_W-1:0] clr;
      logic ch_hit;
      logic [1:0] ci;
      logic [4:0] ro;
      logic hit;
      logic [31:0] rd;
      a = 1'b0;
      b = 1'b0;
      ea = 1'b0;
      eb = 1'b0;
      pulse = 1'b0;
      up = 1'b0;
      gate = 1'b0;
      run = 1'b0;
      ovf = 1'b0;
      unf = 1'b0;
      nv = '0;
      ev = '0;
      set = '0;
      clr = '0;
      rd = '0;
      hit = 1'b0;
      hw = 1'b0;
      hw_rise = 1'b0;
      hw_fall = 1'b0;
      ch_hit = 1'b0;
      ci = 2'h0;
      ro = 5'h00;
      st_nxt = st_r;
      // three stage synchronisers; a level is taken once stages two and three agree
      st_nxt.s1 = {hw_gate, cnt_b, cnt_a};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int k = 0; k <= 2*NUM_CH; k++) begin
         if (st_r.s2[k] == st_r.s3[k]) begin
            st_nxt.filt[k] = st_r.s3[k];
         end
      end
      hw = st_nxt.filt[2*NUM_CH];
      hw_rise = hw & ~st_r.filt[2*NUM_CH];
      hw_fall = ~hw & st_r.filt[2*NUM_CH];
      for (int i = 0; i < NUM_CH; i++) begin
         a = st_nxt.filt[i];
         b = st_nxt.filt[NUM_CH+i];
         ea = a ^ st_r.filt[i];
         eb = b ^ st_r.filt[NUM_CH+i];
         unique case (st_r.ch[i].eval) // R15
            FCG_EV_PULSEDIR: begin
               pulse = ea & a;
               up = b;
            end
            FCG_EV_SINGLE: begin
               pulse = ea & a;
               up = ~b;
            end
            FCG_EV_DOUBLE: begin
               pulse = ea;
               up = a ^ b;
            end
            FCG_EV_QUAD: begin
               pulse = ea | eb;
               up = ea ? (a ^ b) : ~(a ^ b);
            end
         endcase
         up = up ^ st_r.ch[i].inv; // R16
         // only the last channel owns a hardware gate
         gate = st_r.ch[i].swg;
         if (i == NUM_CH-1 && st_r.ch[i].hwg) begin
            gate = st_r.ch[i].swg & hw; // R14
         end
         st_nxt.ch[i].gate_q = gate;
         ovf = 1'b0;
         unf = 1'b0;
         nv = up ? 32'(st_r.ch[i].cnt + 32'h1) : 32'(st_r.ch[i].cnt - 32'h1);
         run = gate & st_r.ch[i].gate_q & ~st_r.ch[i].done & pulse;
         if (st_r.ch[i].mode == FCG_UNCONF) begin
            // deactivated: held at zero, no events
            st_nxt.ch[i].cnt = CNT_RST; // R5
            st_nxt.ch[i].done = 1'b0;
            run = 1'b0;
         end else if (gate & ~st_r.ch[i].gate_q) begin
            st_nxt.ch[i].done = 1'b0;
            if (!st_r.ch[i].stop) begin
               st_nxt.ch[i].cnt = st_r.ch[i].load; // R10
            end
         end else if (run) begin
            // closed gate freezes cnt; stop policy keeps it for reopening
            if (st_r.ch[i].mode != FCG_ENDLESS && st_r.ch[i].mdir == FCG_DIR_UP && up
                && st_r.ch[i].cnt == 32'(st_r.ch[i].endv - 32'h1)) begin
               nv = st_r.ch[i].load; // R7 R9
               ovf = 1'b1;
            end else if (st_r.ch[i].mode != FCG_ENDLESS && st_r.ch[i].mdir == FCG_DIR_DOWN
                && !up && st_r.ch[i].cnt == 32'h1) begin
               nv = st_r.ch[i].start; // R8 R9
               unf = 1'b1;
            end else begin
               ovf = up & (st_r.ch[i].cnt == CNT_MAX); // R6 R17
               unf = ~up & (st_r.ch[i].cnt == CNT_MIN); // R6 R17
            end
            st_nxt.ch[i].cnt = nv; // R11
            if (st_r.ch[i].mode == FCG_ONCE && (ovf | unf)) begin
               st_nxt.ch[i].done = 1'b1;
            end
         end
         if (st_r.ch[i].mode != FCG_UNCONF) begin
            if (i == NUM_CH-1 && st_r.ch[i].hwg) begin
               ev[i*NUM_EV+EV_GOPEN] = hw_rise; // R3
               ev[i*NUM_EV+EV_GCLOSE] = hw_fall; // R3
            end
            ev[i*NUM_EV+EV_CMP] = run & (nv == st_r.ch[i].cmp); // R3
            ev[i*NUM_EV+EV_PULSE] = run; // R3
            ev[i*NUM_EV+EV_OVF] = ovf; // R17
            ev[i*NUM_EV+EV_UNF] = unf; // R17
         end
         if (st_r.irq_sel != FCG_IRQ_NONE) begin
            set[i*NUM_EV +: NUM_EV] = ev[i*NUM_EV +: NUM_EV] & st_r.ch[i].evt_en; // R2 R3
         end
      end
      // an event hitting a still pending flag is lost
      if (st_r.irq_sel == FCG_IRQ_DIAG && |(set & st_r.sts)) begin
         set[STS_LOST] = 1'b1; // R4
      end

      // register decode
      ci = paddr[6:5];
      ro = paddr[4:0];
      ch_hit = paddr[11:7] == 5'h00 && paddr[1:0] == 2'h0 && ro <= OFS_START;
      if (ch_hit) begin
         hit = 1'b1;
         unique case (ro)
            OFS_CFG: rd = fcg_cfg_word(st_r.ch[ci]);
            OFS_LOAD: rd = st_r.ch[ci].load;
            OFS_END: rd = st_r.ch[ci].endv;
            OFS_CMP: rd = st_r.ch[ci].cmp;
            OFS_START: rd = st_r.ch[ci].start;
            default: hit = 1'b0;
         endcase
      end else begin
         unique case (paddr)
            OFS_IRQ_SEL: begin
               hit = 1'b1;
               rd = 32'(st_r.irq_sel);
            end
            OFS_IRQ_STS: begin
               hit = 1'b1;
               rd = 32'(st_r.sts);
            end
            OFS_IRQ_MASK: begin
               hit = 1'b1;
               rd = 32'(st_r.mask);
            end
            OFS_COUNT0, OFS_COUNT1, OFS_COUNT2, OFS_COUNT3: begin
               hit = ~pwrite;
               rd = st_r.ch[paddr[3:2]].cnt; // R1
            end
            default: hit = 1'b0;
         endcase
      end
      if (setup) begin
         st_nxt.prdata = pwrite ? 32'h0 : rd;
         st_nxt.err = ~hit;
      end

      if (access_wr && !st_r.err) begin
         if (ch_hit) begin
            unique case (ro)
               OFS_CFG: begin
                  st_nxt.ch[ci].mode = fcg_mode_e'(pwdata[CFG_MODE_LSB +: 2]);
                  st_nxt.ch[ci].mdir = fcg_mdir_e'(pwdata[CFG_MDIR_LSB +: 2]);
                  st_nxt.ch[ci].stop = pwdata[CFG_STOP];
                  st_nxt.ch[ci].eval = fcg_eval_e'(pwdata[CFG_EVAL_LSB +: 2]);
                  st_nxt.ch[ci].inv = pwdata[CFG_INV];
                  st_nxt.ch[ci].hwg = pwdata[CFG_HWG];
                  st_nxt.ch[ci].swg = pwdata[CFG_SWG];
                  st_nxt.ch[ci].evt_en = pwdata[CFG_EVT_LSB +: NUM_EV];
               end
               OFS_LOAD: st_nxt.ch[ci].load = pwdata;
               OFS_END: begin
                  // below the floor, negatives included, clamps to the floor
                  st_nxt.ch[ci].endv = ($signed(pwdata) < $signed(END_MIN)) ? END_MIN
                                       : pwdata; // R13
               end
               OFS_CMP: st_nxt.ch[ci].cmp = pwdata;
               OFS_START: st_nxt.ch[ci].start = pwdata;
               default: ;
            endcase
         end else begin
            unique case (paddr)
               OFS_IRQ_SEL: st_nxt.irq_sel = fcg_irqsel_e'(pwdata[1:0]);
               OFS_IRQ_STS: clr = pwdata[STS_W-1:0];
               OFS_IRQ_MASK: st_nxt.mask = pwdata[STS_W-1:0];
               default: ;
            endcase
         end
      end
      // set wins over a write-one clear in the same cycle
      st_nxt.sts = (st_r.sts & ~clr) | set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{ch: {NUM_CH{CH_RST}}, irq_sel: FCG_IRQ_NONE, default: '0}; // R12 R13
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : fcg_counter

// File: dv/fcg_enc_model.sv
// pulse, direction and gate source for the counter pins
`timescale 1ns/1ps
module fcg_enc_model (
   input wire logic pclk,
   output logic [3:0] cnt_a,
   output logic [3:0] cnt_b,
   output logic hw_gate
);
   initial begin
      cnt_a = 4'h0;
      cnt_b = 4'h0;
      hw_gate = 1'b0;
   end
   // levels held 5 edges, longer than the 3-flop filter needs
   task automatic drive(input int ch, input logic a, input logic b);
      @(posedge pclk);
      cnt_a[ch] <= a;
      cnt_b[ch] <= b;
      repeat (5) @(posedge pclk);
   endtask : drive
   task automatic pulse(input int ch, input logic up);
      drive(ch, 1'b0, up);
      drive(ch, 1'b1, up);
   endtask : pulse
   task automatic gate(input logic g);
      @(posedge pclk);
      hw_gate <= g;
      repeat (5) @(posedge pclk);
   endtask : gate
endmodule : fcg_enc_model

// File: dv/fcg_counter_asserts.sv
// bus and interrupt assertions for the gated counter
`timescale 1ns/1ps
module fcg_counter_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [fcg_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   import fcg_pkg::*;
   logic acc;
   logic cnt_ofs;
   logic ever_sel_r;
   logic [31:0] mask_r;
   logic [1:0] mode_r [NUM_CH];
   assign acc = psel && penable;
   assign cnt_ofs = paddr[11:4] == 8'h33;
   // shadows of written config, so irq and reads can be judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ever_sel_r <= 1'b0;
         mask_r <= 32'h0;
         for (int i = 0; i < NUM_CH; i++) begin
            mode_r[i] <= 2'h0;
         end
      end else if (acc && pwrite) begin
         if (paddr == OFS_IRQ_SEL && pwdata[1:0] != 2'h0) begin
            ever_sel_r <= 1'b1;
         end
         if (paddr == OFS_IRQ_MASK) begin
            mask_r <= pwdata;
         end
         for (int i = 0; i < NUM_CH; i++) begin
            if (paddr == 12'(i * 32)) begin
               mode_r[i] <= pwdata[1:0];
            end
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_zero_a: assert property (psel |-> pready == penable)
      else $error("pready not equal to access phase");
   ro_count_a: assert property (acc && pwrite && cnt_ofs |-> pslverr)
      else $error("count write not refused");
   unmapped_a: assert property (acc && paddr == 12'hffc |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   wr_rdata_a: assert property (acc && pwrite |-> prdata == 32'h0)
      else $error("read data not zero on write");
   rdata_hold_a: assert property (acc && !pwrite |=> $stable(prdata))
      else $error("read data changed after access");
   irq_none_a: assert property (!ever_sel_r |-> !irq)
      else $error("interrupt with selection none");
   irq_mask_a: assert property (mask_r[STS_W-1:0] == 25'h0 |-> !irq)
      else $error("interrupt with all masked");
   unconf_zero_a: assert property (acc && !pwrite && cnt_ofs && mode_r[paddr[3:2]] == 2'h0
      |-> prdata == 32'h0)
      else $error("unconfigured channel count not zero");
endmodule : fcg_counter_asserts

// File: dv/testbench.sv
// directed apb tests of the four channel gated counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
   import fcg_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_gate, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, ex;
   logic errv;
   logic [3:0] cnt_a, cnt_b;
   int error_cnt, total_checks;
   fcg_counter fcg_counter_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cnt_a(cnt_a), .cnt_b(cnt_b), .hw_gate(hw_gate), .irq(irq));
   fcg_enc_model fcg_enc_model_i (.pclk(pclk), .cnt_a(cnt_a), .cnt_b(cnt_b),
      .hw_gate(hw_gate));
   always #2 pclk = ~pclk;
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      `CHK($sformatf("reg %h", a), e, rdv)
   endtask : rchk
   task automatic pul(input int ch, input logic up, input int n);
      repeat (n) fcg_enc_model_i.pulse(ch, up);
   endtask : pul
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rchk(OFS_CFG, 32'h0);
      rchk(OFS_START, START_RST);
      rchk(OFS_COUNT0, CNT_RST);
      rchk(12'hffc, 32'h0);
      `CHK("unmapped err", 1'b1, errv)
      wr(OFS_COUNT1, 32'h1);
      `CHK("ro err", 1'b1, errv)
      wr(OFS_END, 32'h1);
      rchk(OFS_END, END_MIN);
      $display("test reset done");
      wr(OFS_LOAD, 32'h5);
      wr(OFS_CFG, 32'h201);
      rchk(OFS_COUNT0, 32'h5);
      pul(0, 1'b1, 3);
      rchk(OFS_COUNT0, 32'h8);
      pul(0, 1'b0, 1);
      rchk(OFS_COUNT0, 32'h7);
      wr(OFS_CFG, 32'h281);
      pul(0, 1'b1, 1);
      rchk(OFS_COUNT0, 32'h6);
      wr(OFS_CFG, 32'h081);
      wr(OFS_CFG, 32'h281);
      rchk(OFS_COUNT0, 32'h5);
      fcg_enc_model_i.drive(0, 1'b0, 1'b0);
      ex = 32'h5;
      for (int e = 1; e < 4; e++) begin
         wr(OFS_CFG, 32'h201 | (e << 5));
         fcg_enc_model_i.drive(0, 1'b1, 1'b0);
         fcg_enc_model_i.drive(0, 1'b1, 1'b1);
         fcg_enc_model_i.drive(0, 1'b0, 1'b1);
         fcg_enc_model_i.drive(0, 1'b0, 1'b0);
         ex = ex + (1 << (e - 1));
         rchk(OFS_COUNT0, ex);
      end
      $display("test channel 0 done");
      wr(12'h020, 32'h211);
      pul(1, 1'b1, 2);
      wr(12'h020, 32'h011);
      pul(1, 1'b1, 1);
      rchk(OFS_COUNT1, 32'h2);
      wr(12'h020, 32'h211);
      pul(1, 1'b1, 1);
      rchk(OFS_COUNT1, 32'h3);
      $display("test stop policy done");
      wr(12'h048, 32'h3);
      wr(OFS_IRQ_MASK, 32'h10000);
      wr(12'h040, 32'h100206);
      pul(2, 1'b1, 3);
      rchk(OFS_COUNT2, 32'h0);
      rchk(OFS_IRQ_STS, 32'h0);
      wr(OFS_IRQ_SEL, 32'h1);
      pul(2, 1'b1, 3);
      rchk(OFS_IRQ_STS, 32'h10000);
      `CHK("irq", 1'b1, irq)
      wr(OFS_IRQ_SEL, 32'h2);
      pul(2, 1'b1, 3);
      rchk(OFS_IRQ_STS, 32'h1010000);
      wr(OFS_IRQ_STS, 32'h1ffffff);
      rchk(OFS_IRQ_STS, 32'h0);
      `CHK("irq", 1'b0, irq)
      wr(12'h040, 32'h100205);
      pul(2, 1'b1, 4);
      rchk(OFS_COUNT2, 32'h4);
      wr(12'h050, 32'h2);
      wr(12'h044, 32'h2);
      wr(12'h040, 32'h00a);
      wr(12'h040, 32'h20a);
      pul(2, 1'b0, 2);
      rchk(OFS_COUNT2, 32'h2);
      $display("test channel 2 done");
      wr(12'h060, 32'h10301);
      pul(3, 1'b1, 1);
      rchk(OFS_COUNT3, 32'h0);
      fcg_enc_model_i.gate(1'b1);
      rchk(OFS_IRQ_STS, 32'h40000);
      pul(3, 1'b1, 1);
      rchk(OFS_COUNT3, 32'h1);
      wr(12'h060, 32'h201);
      fcg_enc_model_i.gate(1'b0);
      pul(3, 1'b1, 1);
      rchk(OFS_COUNT3, 32'h2);
      $display("test hardware gate done");
      report_and_stop();
   end
endmodule : testbench
bind fcg_counter fcg_counter_asserts fcg_counter_asserts_i (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
